/* File: hw/rtcai_consts.vh */
`ifndef RTCAI_CONSTS_VH
`define RTCAI_CONSTS_VH

// timebase
`define RTCAI_OSC_HZ 32768
`define RTCAI_TICKS_PER_SEC 15'h7FFF
// alarm 1 pulse: 62.5 ms as 2048 timebase periods
`define RTCAI_PULSE_MS_X10 625
`define RTCAI_PULSE_TICKS 12'h7FF

// field limits (binary, 24-hour)
`define RTCAI_SEC_MAX 6'h3B
`define RTCAI_MIN_MAX 6'h3B
`define RTCAI_HOUR_MAX 5'h17
`define RTCAI_DOW_MAX 3'h7
`define RTCAI_DOW_MIN 3'h1
`define RTCAI_MONTH_MAX 4'hC
`define RTCAI_YEAR_MAX 7'h63

// mask field positions: {dow, hour, min, sec}
`define RTCAI_MSK_SEC 0
`define RTCAI_MSK_MIN 1
`define RTCAI_MSK_HOUR 2
`define RTCAI_MSK_DOW 3

// reset values (2000-01-01, saturday = 7)
`define RTCAI_RST_DATE 5'h01
`define RTCAI_RST_MONTH 4'h1
`define RTCAI_RST_YEAR 7'h00
`define RTCAI_RST_DOW 3'h7

`endif

/* File: hw/rtcai_cmp.v */
`timescale 1ns/1ps
`default_nettype none
`include "rtcai_consts.vh"

module rtcai_cmp (
  // clock and reset
  input wire clk,
  input wire srst,
  // running time
  input wire [5:0] sec,
  input wire [5:0] min,
  input wire [4:0] hour,
  input wire [2:0] dow,
  // alarm setting, mask bit set = don't care
  input wire [5:0] al_sec,
  input wire [5:0] al_min,
  input wire [4:0] al_hour,
  input wire [2:0] al_dow,
  input wire [3:0] al_mask,
  // result
  output reg match_q
);

  wire match_d;

  // programmable field combination
  assign match_d = (al_mask[`RTCAI_MSK_SEC] | (sec == al_sec)) &
                   (al_mask[`RTCAI_MSK_MIN] | (min == al_min)) &
                   (al_mask[`RTCAI_MSK_HOUR] | (hour == al_hour)) &
                   (al_mask[`RTCAI_MSK_DOW] | (dow == al_dow));

  always @(posedge clk) begin
    if (srst) begin
      match_q <= 1'b0;
    end else begin
      match_q <= match_d;
    end
  end

endmodule
`default_nettype wire

/* File: hw/rtcai_top.v */
// Behaviour
// - active-low interrupt asserted by alarm 0
// - held while alarm 0 flag and enable set
// - active-high interrupt asserted by alarm 1
// - alarm 1 gives one 62.5 ms pulse
// - pulse output low whenever inactive
// - alarm 1 pulses only on backup power
// - alarms compare masked sec/min/hour/day fields
// - counters advance seconds to year, leap years
// - timebase is 32.768 kHz oscillator input
`timescale 1ns/1ps
`default_nettype none
`include "rtcai_consts.vh"

module rtcai_top (
  // clock and reset
  input wire clk,
  input wire srst,
  // oscillator pins
  input wire osc_in,
  output reg osc_out,
  // supply state, high = running from backup supply or battery
  input wire backup_supply,
  // time load
  input wire time_load,
  input wire [5:0] load_sec,
  input wire [5:0] load_min,
  input wire [4:0] load_hour,
  input wire [2:0] load_dow,
  input wire [4:0] load_date,
  input wire [3:0] load_month,
  input wire [6:0] load_year,
  // alarm 0 setting
  input wire [5:0] al0_sec,
  input wire [5:0] al0_min,
  input wire [4:0] al0_hour,
  input wire [2:0] al0_dow,
  input wire [3:0] al0_mask,
  input wire al0_irq_en,
  input wire al0_flag_clr,
  // alarm 1 setting
  input wire [5:0] al1_sec,
  input wire [5:0] al1_min,
  input wire [4:0] al1_hour,
  input wire [2:0] al1_dow,
  input wire [3:0] al1_mask,
  input wire al1_irq_en,
  input wire al1_flag_clr,
  // interrupts
  output reg alarm0_irq_n,
  output reg alarm0_irq_oe_n,
  output reg alarm1_irq_pulse,
  // status and time
  output reg al0_flag_q,
  output reg al1_flag_q,
  output reg [5:0] sec_q,
  output reg [5:0] min_q,
  output reg [4:0] hour_q,
  output reg [2:0] dow_q,
  output reg [4:0] date_q,
  output reg [3:0] month_q,
  output reg [6:0] year_q
);

  reg osc_s1_q;
  reg osc_s2_q;
  reg osc_s3_q;
  reg bk_s1_q;
  reg bk_s2_q;
  reg tick_q;
  reg [14:0] pre_q;
  reg sec_tick_q;
  reg cmp_dly_q;
  reg cmp_tick_q;
  reg [11:0] pulse_cnt_q;
  wire m0;
  wire m1;
  wire al0_flag_d;
  wire al1_flag_d;
  wire [4:0] dim;

  // days in month, leap every fourth year through 2099
  function [4:0] days_in;
    input [3:0] mon;
    input [6:0] yr;
    begin
      case (mon)
        4'h2: days_in = (yr[1:0] == 2'h0) ? 5'h1D : 5'h1C;
        4'h4, 4'h6, 4'h9, 4'hB: days_in = 5'h1E;
        default: days_in = 5'h1F;
      endcase
    end
  endfunction

  assign dim = days_in(month_q, year_q);

  // oscillator sampling and timebase tick
  always @(posedge clk) begin
    if (srst) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
      bk_s1_q <= 1'b0;
      bk_s2_q <= 1'b0;
      tick_q <= 1'b0;
      osc_out <= 1'b1;
    end else begin
      osc_s1_q <= osc_in;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
      bk_s1_q <= backup_supply;
      bk_s2_q <= bk_s1_q;
      tick_q <= osc_s2_q & ~osc_s3_q;
      osc_out <= ~osc_s2_q;
    end
  end

  // one-second prescaler
  always @(posedge clk) begin
    if (srst || time_load) begin
      pre_q <= 15'h0000;
      sec_tick_q <= 1'b0;
    end else begin
      sec_tick_q <= 1'b0;
      if (tick_q) begin
        if (pre_q == `RTCAI_TICKS_PER_SEC) begin
          pre_q <= 15'h0000;
          sec_tick_q <= 1'b1;
        end else begin
          pre_q <= pre_q + 15'h0001;
        end
      end
    end
  end

  // calendar counters
  always @(posedge clk) begin
    if (srst) begin
      sec_q <= 6'h00;
      min_q <= 6'h00;
      hour_q <= 5'h00;
      dow_q <= `RTCAI_RST_DOW;
      date_q <= `RTCAI_RST_DATE;
      month_q <= `RTCAI_RST_MONTH;
      year_q <= `RTCAI_RST_YEAR;
    end else if (time_load) begin
      sec_q <= load_sec;
      min_q <= load_min;
      hour_q <= load_hour;
      dow_q <= load_dow;
      date_q <= load_date;
      month_q <= load_month;
      year_q <= load_year;
    end else if (sec_tick_q) begin
      if (sec_q != `RTCAI_SEC_MAX) begin
        sec_q <= sec_q + 6'h01;
      end else begin
        sec_q <= 6'h00;
        if (min_q != `RTCAI_MIN_MAX) begin
          min_q <= min_q + 6'h01;
        end else begin
          min_q <= 6'h00;
          if (hour_q != `RTCAI_HOUR_MAX) begin
            hour_q <= hour_q + 5'h01;
          end else begin
            hour_q <= 5'h00;
            dow_q <= (dow_q == `RTCAI_DOW_MAX) ? `RTCAI_DOW_MIN : dow_q + 3'h1;
            if (date_q < dim) begin
              date_q <= date_q + 5'h01;
            end else begin
              date_q <= 5'h01;
              if (month_q != `RTCAI_MONTH_MAX) begin
                month_q <= month_q + 4'h1;
              end else begin
                month_q <= 4'h1;
                year_q <= (year_q == `RTCAI_YEAR_MAX) ? 7'h00 : year_q + 7'h01;
              end
            end
          end
        end
      end
    end
  end

  // alarm comparators
  rtcai_cmp u_cmp0 (
    .clk(clk),
    .srst(srst),
    .sec(sec_q),
    .min(min_q),
    .hour(hour_q),
    .dow(dow_q),
    .al_sec(al0_sec),
    .al_min(al0_min),
    .al_hour(al0_hour),
    .al_dow(al0_dow),
    .al_mask(al0_mask),
    .match_q(m0)
  );

  rtcai_cmp u_cmp1 (
    .clk(clk),
    .srst(srst),
    .sec(sec_q),
    .min(min_q),
    .hour(hour_q),
    .dow(dow_q),
    .al_sec(al1_sec),
    .al_min(al1_min),
    .al_hour(al1_hour),
    .al_dow(al1_dow),
    .al_mask(al1_mask),
    .match_q(m1)
  );

  // check matches once the new second has settled; set wins over clear
  assign al0_flag_d = (cmp_tick_q & m0) | (al0_flag_q & ~al0_flag_clr);
  assign al1_flag_d = (cmp_tick_q & m1) | (al1_flag_q & ~al1_flag_clr);

  always @(posedge clk) begin
    if (srst) begin
      cmp_dly_q <= 1'b0;
      cmp_tick_q <= 1'b0;
      al0_flag_q <= 1'b0;
      al1_flag_q <= 1'b0;
      alarm0_irq_n <= 1'b1;
      alarm0_irq_oe_n <= 1'b1;
    end else begin
      // wait for counter update, then comparator register
      cmp_dly_q <= sec_tick_q;
      cmp_tick_q <= cmp_dly_q;
      al0_flag_q <= al0_flag_d;
      al1_flag_q <= al1_flag_d;
      alarm0_irq_n <= ~(al0_flag_d & al0_irq_en);
      alarm0_irq_oe_n <= ~(al0_flag_d & al0_irq_en);
    end
  end

  // alarm 1 pulse generator
  always @(posedge clk) begin
    if (srst) begin
      pulse_cnt_q <= 12'h000;
      alarm1_irq_pulse <= 1'b0;
    end else if (alarm1_irq_pulse) begin
      if (tick_q) begin
        if (pulse_cnt_q == `RTCAI_PULSE_TICKS) begin
          alarm1_irq_pulse <= 1'b0;
          pulse_cnt_q <= 12'h000;
        end else begin
          pulse_cnt_q <= pulse_cnt_q + 12'h001;
        end
      end
    end else if (cmp_tick_q && m1 && al1_irq_en && bk_s2_q) begin
      alarm1_irq_pulse <= 1'b1;
      pulse_cnt_q <= 12'h000;
    end
  end

endmodule
`default_nettype wire

/* File: sim/rtcai_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcai_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // inputs
  input wire logic osc_in,
  input wire logic backup_supply,
  input wire logic time_load,
  input wire logic [5:0] al0_sec,
  input wire logic [3:0] al0_mask,
  input wire logic al0_irq_en,
  // outputs
  input wire logic osc_out,
  input wire logic alarm0_irq_n,
  input wire logic alarm1_irq_pulse,
  input wire logic al0_flag_q,
  input wire logic al1_flag_q,
  input wire logic [5:0] sec_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic osc_d_q;
  logic [11:0] tick_q;
  logic [1:0] up_q;
  // timebase ticks seen while the pulse is high
  always @(posedge clk) begin
    osc_d_q <= osc_out;
    if (srst) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
    if (srst || !alarm1_irq_pulse) tick_q <= 12'h000;
    else if (osc_d_q && !osc_out) tick_q <= tick_q + 12'h001;
  end
  property p_irq0_set;
    al0_flag_q && $past(al0_irq_en) |-> !alarm0_irq_n;
  endproperty
  a_irq0_set: assert property (p_irq0_set) else $error("irq0 not low");
  property p_irq0_hold;
    !alarm0_irq_n |-> al0_flag_q && $past(al0_irq_en);
  endproperty
  a_irq0_hold: assert property (p_irq0_hold) else $error("irq0 low without cause");
  property p_pulse_rise;
    $rose(alarm1_irq_pulse) |-> al1_flag_q;
  endproperty
  a_pulse_rise: assert property (p_pulse_rise) else $error("pulse without alarm");
  property p_pulse_backup;
    $rose(alarm1_irq_pulse) |-> $past(backup_supply, 3);
  endproperty
  a_pulse_backup: assert property (p_pulse_backup) else $error("pulse on primary");
  property p_pulse_len;
    $fell(alarm1_irq_pulse) |-> tick_q == 12'h800;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse length");
  property p_pulse_gap;
    $fell(alarm1_irq_pulse) |=> !alarm1_irq_pulse [*8];
  endproperty
  a_pulse_gap: assert property (p_pulse_gap) else $error("pulse not low");
  property p_sec_step;
    $changed(sec_q) && !$past(time_load) |->
      sec_q == ($past(sec_q) == 6'h3B ? 6'h00 : $past(sec_q) + 6'h01);
  endproperty
  a_sec_step: assert property (p_sec_step) else $error("second step");
  property p_al0_cause;
    $rose(al0_flag_q) |-> al0_mask[0] || sec_q == al0_sec;
  endproperty
  a_al0_cause: assert property (p_al0_cause) else $error("alarm0 mismatch");
  property p_osc_out;
    up_q == 2'h3 |-> osc_out == !$past(osc_in, 3);
  endproperty
  a_osc_out: assert property (p_osc_out) else $error("osc_out not inverted input");
endmodule
bind rtcai_top rtcai_asserts rtcai_asserts_inst (.clk(clk), .srst(srst), .osc_in(osc_in),
  .backup_supply(backup_supply), .time_load(time_load), .al0_sec(al0_sec),
  .al0_mask(al0_mask), .al0_irq_en(al0_irq_en), .osc_out(osc_out),
  .alarm0_irq_n(alarm0_irq_n), .alarm1_irq_pulse(alarm1_irq_pulse),
  .al0_flag_q(al0_flag_q), .al1_flag_q(al1_flag_q), .sec_q(sec_q));
`default_nettype wire

/* File: sim/rtcai_host.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcai_host (
  // clock
  input wire logic clk,
  // interrupt lines
  input wire logic alarm0_irq_oe_n,
  input wire logic alarm1_irq_pulse,
  // host view
  output logic irq0_pin,
  output var int pulse_len
);
  int run_q = 0;
  // pull-up when released
  assign irq0_pin = alarm0_irq_oe_n ? 1'b1 : 1'b0;
  always @(posedge clk) begin
    if (alarm1_irq_pulse) run_q <= run_q + 1;
    else if (run_q != 0) begin
      pulse_len <= run_q;
      run_q <= 0;
    end
  end
endmodule
`default_nettype wire

/* File: sim/rtc_alarm_interrupt_outputs_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_interrupt_outputs_bench;
  logic clk = 0, srst = 1, osc_in = 0, backup_supply = 1, time_load = 0;
  logic [5:0] load_sec = 6'h00, load_min = 6'h05, al0_sec = 6'h01, al0_min = 6'h05;
  logic [5:0] al1_sec = 6'h01, al1_min = 6'h05;
  logic [4:0] load_hour = 5'h17, al0_hour = 5'h17;
  logic [2:0] load_dow = 3'h3, al0_dow = 3'h3;
  logic [3:0] al0_mask = 4'h0, al1_mask = 4'hC;
  logic al0_irq_en = 1, al1_irq_en = 1, al0_flag_clr = 0, al1_flag_clr = 0;
  logic alarm0_irq_n, alarm0_irq_oe_n, alarm1_irq_pulse, al0_flag_q, al1_flag_q, irq0_pin;
  logic osc_out;
  logic [5:0] sec_q, min_q;
  logic [4:0] hour_q, date_q;
  logic [2:0] dow_q;
  logic [3:0] month_q;
  logic [6:0] year_q;
  int n_errors = 0, n_compared = 0, n_cyc = 0, pulse_len;
  rtcai_top rtcai_top_inst (.clk(clk), .srst(srst), .osc_in(osc_in), .osc_out(osc_out),
    .backup_supply(backup_supply), .time_load(time_load), .load_sec(load_sec),
    .load_min(load_min), .load_hour(load_hour), .load_dow(load_dow), .load_date(5'h01),
    .load_month(4'h1), .load_year(7'h00), .al0_sec(al0_sec), .al0_min(al0_min),
    .al0_hour(al0_hour), .al0_dow(al0_dow), .al0_mask(al0_mask), .al0_irq_en(al0_irq_en),
    .al0_flag_clr(al0_flag_clr), .al1_sec(al1_sec), .al1_min(al1_min), .al1_hour(5'h00),
    .al1_dow(3'h1), .al1_mask(al1_mask), .al1_irq_en(al1_irq_en),
    .al1_flag_clr(al1_flag_clr), .alarm0_irq_n(alarm0_irq_n),
    .alarm0_irq_oe_n(alarm0_irq_oe_n), .alarm1_irq_pulse(alarm1_irq_pulse),
    .al0_flag_q(al0_flag_q), .al1_flag_q(al1_flag_q), .sec_q(sec_q), .min_q(min_q),
    .hour_q(hour_q), .dow_q(dow_q), .date_q(date_q), .month_q(month_q), .year_q(year_q));
  rtcai_host rtcai_host_inst (.clk(clk), .alarm0_irq_oe_n(alarm0_irq_oe_n),
    .alarm1_irq_pulse(alarm1_irq_pulse), .irq0_pin(irq0_pin), .pulse_len(pulse_len));
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    n_cyc++;
    if (n_cyc[0]) osc_in <= #1 ~osc_in; // four-cycle timebase period
    if (n_cyc == 150000) begin
      n_errors++;
      end_sim;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic t_match;
    @(posedge clk);
    #1 time_load = 1;
    @(posedge clk);
    #1 time_load = 0;
    check(min_q, 5);
    check(sec_q, 0);
    check(hour_q, 5'h17);
    check(dow_q, 3'h3);
    check(date_q, 1);
    check(month_q, 1);
    check(year_q, 0);
    for (int i = 0; i < 140000 && !al0_flag_q; i++) begin
      @(posedge clk);
      #1;
    end
    check(sec_q, 1);
    check(alarm0_irq_n, 0);
    check(irq0_pin, 0);
    check(alarm1_irq_pulse, 1);
    check(al1_flag_q, 1);
  endtask
  task automatic t_hold;
    al0_irq_en = 0;
    repeat (2) @(posedge clk);
    #1 check(alarm0_irq_n, 1);
    check(al0_flag_q, 1);
    al0_irq_en = 1;
    repeat (2) @(posedge clk);
    #1 check(alarm0_irq_n, 0);
    al0_flag_clr = 1;
    @(posedge clk);
    #1 al0_flag_clr = 0;
    @(posedge clk);
    #1 check(alarm0_irq_n, 1);
  endtask
  task automatic t_pulse;
    check(alarm1_irq_pulse, 1);
    for (int i = 0; i < 9000 && alarm1_irq_pulse; i++) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1 check(alarm1_irq_pulse, 0);
    check(pulse_len >= 8189 && pulse_len <= 8192, 1);
    al1_flag_clr = 1;
    @(posedge clk);
    #1 al1_flag_clr = 0;
    check(al1_flag_q, 0);
    check(alarm1_irq_pulse, 0);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1 srst = 0;
    check(alarm0_irq_n, 1);
    check(alarm1_irq_pulse, 0);
    t_match;
    t_hold;
    t_pulse;
    end_sim;
  end
endmodule
`default_nettype wire
